// ---- common/pwmc_pkg.sv ----
// Notes on behaviour
// - Opaque modes put background where mask bit clear
// - Foreground goes where mask bit is set
// - Mask from write data or drawing data
// - Green or blue increment writes change background
// - Background colour clears to zero at reset
// - Plane mask gates each pixel bit update
// - Plane mask has no reset value
// - Pixel mask acts only in three modes
// - Opaque stipple write covers 32 masked pixels
// - 8- and 32-bit simple modes AND mask with byte lanes
// - 12- and 24-bit simple modes use mask bit zero
// - One-shot mask reverts to ones after use
// - Persistent mask held until next written
// - Mode register bit 23 shows one-shot state
// - Pixel mask resets to all ones
package pwmc_pkg;

  // Byte offsets on the register bus
  localparam logic [7:0] OFS_BACKGROUND   = 8'h00;
  localparam logic [7:0] OFS_PLANE_MASK   = 8'h04;
  localparam logic [7:0] OFS_PIXEL_PERSIST = 8'h08;
  localparam logic [7:0] OFS_PIXEL_ONESHOT = 8'h0C;
  localparam logic [7:0] OFS_GREEN_INC    = 8'h10;
  localparam logic [7:0] OFS_BLUE_INC     = 8'h14;
  localparam logic [7:0] OFS_MODE         = 8'h18;
  localparam logic [7:0] OFS_FOREGROUND   = 8'h1C;
  localparam logic [7:0] OFS_DRAW_DATA    = 8'h20;

  // Mode register fields
  localparam int MODE_SEL_LSB   = 0;  // Drawing mode, 3 bits
  localparam int MODE_DEPTH_LSB = 4;  // Destination depth, 2 bits
  localparam int MODE_ONESHOT_BIT = 23; // Pixel mask one-shot state

  // Values after reset
  localparam logic [31:0] RST_BACKGROUND = 32'h0000_0000;
  localparam logic [31:0] RST_FOREGROUND = 32'h0000_0000;
  localparam logic [31:0] RST_PIXEL_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_DRAW_DATA  = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO       = 32'h0000_0000;

  // Cycles from request to acknowledge on the bus
  localparam int BUS_ACK_CYCLES = 1;

  // Drawing modes
  typedef enum logic [2:0] {
    PWMC_SIMPLE,
    PWMC_SIMPLE_Z,
    PWMC_OPQ_STIPPLE,
    PWMC_TRN_STIPPLE,
    PWMC_OPQ_LINE,
    PWMC_TRN_LINE,
    PWMC_OPQ_FILL,
    PWMC_TRN_FILL
  } pwmc_mode_t;

  // Destination depths
  typedef enum logic [1:0] {
    PWMC_BPP8,
    PWMC_BPP12,
    PWMC_BPP24,
    PWMC_BPP32
  } pwmc_depth_t;

  // Kinds of operation issued by the command side
  typedef enum logic [1:0] {
    PWMC_OP_FB_WRITE,
    PWMC_OP_COPY_TARGET,
    PWMC_OP_SLOPE,
    PWMC_OP_SPAN_WIDTH
  } pwmc_op_t;

endpackage : pwmc_pkg

// ---- design/pwmc_mask_calc.sv ----
`timescale 1ns/1ps
// Combinational mask resolution for one operation
module pwmc_mask_calc (
  input  wire pwmc_pkg::pwmc_mode_t  mode_i,
  input  wire pwmc_pkg::pwmc_depth_t depth_i,
  input  wire pwmc_pkg::pwmc_op_t    kind_i,
  input  wire logic [31:0]           wr_data_i,
  input  wire logic [31:0]           draw_data_i,
  input  wire logic [31:0]           pix_mask_i,
  input  wire logic [3:0]            bus_be_i,
  output logic [31:0]                fg_sel_o,
  output logic [31:0]                pix_en_o,
  output logic [3:0]                 byte_en_o
);
  import pwmc_pkg::*;

  logic        fill_mode;  // Fill-mode framebuffer writes take mask from drawing data
  logic        opaque;     // Background substituted for clear bits
  logic [31:0] stip_mask;  // Selected stipple or line mask

  // Mask source and per-pixel choice
  always_comb begin
    fill_mode = (mode_i == PWMC_OPQ_FILL) || (mode_i == PWMC_TRN_FILL);
    opaque = (mode_i == PWMC_OPQ_STIPPLE) || (mode_i == PWMC_OPQ_LINE) ||
             (mode_i == PWMC_OPQ_FILL);
    if (kind_i == PWMC_OP_SLOPE || kind_i == PWMC_OP_SPAN_WIDTH) begin
      stip_mask = draw_data_i;
    end else if (kind_i == PWMC_OP_FB_WRITE && fill_mode) begin
      stip_mask = draw_data_i;
    end else begin
      stip_mask = wr_data_i;
    end
    fg_sel_o  = stip_mask;
    pix_en_o  = 32'hFFFF_FFFF;
    byte_en_o = bus_be_i;
    case (mode_i)
      PWMC_OPQ_STIPPLE: begin
        pix_en_o = pix_mask_i;
      end
      PWMC_SIMPLE, PWMC_SIMPLE_Z: begin
        fg_sel_o = 32'h0000_0000;
        if (depth_i == PWMC_BPP12 || depth_i == PWMC_BPP24) begin
          byte_en_o = pix_mask_i[0] ? bus_be_i : 4'h0;
        end else begin
          byte_en_o = pix_mask_i[3:0] & bus_be_i;
        end
      end
      default: begin
        // Transparent modes write only where the mask is set
        if (!opaque) begin
          pix_en_o = stip_mask;
        end
      end
    endcase
    // Opaque line and fill: clear bits get background, all written
    if (opaque) begin
      fg_sel_o = stip_mask;
    end
  end

endmodule : pwmc_mask_calc

// ---- design/pwmc_regs.sv ----
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Mask and colour substitution state with its Wishbone slave
module pwmc_regs (
  input  wire logic        clk_i,          // Core clock
  input  wire logic        rst_i,          // Synchronous reset
  input  wire logic        ce_i,           // Clock enable, freezes state
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Operations from the command side
  input  wire logic        op_valid_i,     // One-cycle operation strobe
  input  wire pwmc_pkg::pwmc_op_t op_kind_i,
  input  wire logic [31:0] op_data_i,      // Write data of the operation
  input  wire logic [3:0]  op_be_i,        // Bus byte mask
  // Resolved operation
  output logic             res_valid_o,
  output logic [31:0]      res_fg_sel_o,   // 1 = foreground per pixel
  output logic [31:0]      res_pix_en_o,   // Per-pixel write enable
  output logic [3:0]       res_byte_en_o,  // Final byte-write mask
  output logic [31:0]      res_plane_mask_o,
  output logic [31:0]      res_fg_o,
  output logic [31:0]      res_bg_o
);
  import pwmc_pkg::*;

  // Stored state
  logic [31:0] background_color;   // Shared with green/blue increments
  logic [31:0] foreground_color;   // Foreground substitution colour
  logic [31:0] plane_write_mask;   // No reset value by design
  logic [31:0] pixel_write_mask;   // Persistent or one-shot
  logic        pix_oneshot;        // Mask is armed for one use
  logic [31:0] drawing_data_reg;   // Mask source for lines, spans, fill
  pwmc_mode_t  mode_sel;           // Current drawing mode
  pwmc_depth_t depth_sel;          // Current destination depth

  // Bus decode helpers
  logic        bus_req;            // Request seen this cycle
  logic        bus_wr;             // Write commits at the ack edge
  logic        hit;                // Address maps to a register
  logic [31:0] rd_word;            // Read mux output

  // Mask resolver outputs
  logic [31:0] calc_fg_sel;
  logic [31:0] calc_pix_en;
  logic [3:0]  calc_byte_en;

  // Merge written bytes into an old word
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  lanes
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Address compare used by every write decode
  function automatic logic is_wr(
    input logic       wr,
    input logic [7:0] adr,
    input logic [7:0] ofs
  );
    return wr && (adr == ofs);
  endfunction : is_wr

  assign bus_req = cyc_i && stb_i;
  // Commit only in the ack cycle, when the master samples ack
  assign bus_wr  = bus_req && ack_o && we_i;

  // Acknowledge one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= bus_req && !ack_o;
    end
  end

  // Background colour, also written through the increment aliases
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      background_color <= RST_BACKGROUND;
    end else if (ce_i) begin
      if (is_wr(bus_wr, adr_i, OFS_BACKGROUND)) begin
        background_color <= merge_bytes(background_color, dat_i, sel_i);
      end else if (is_wr(bus_wr, adr_i, OFS_GREEN_INC)) begin
        // Storage is shared, so an increment write moves the colour
        background_color <= merge_bytes(background_color, dat_i,
                                        sel_i);
      end else if (is_wr(bus_wr, adr_i, OFS_BLUE_INC)) begin
        background_color <= merge_bytes(background_color, dat_i,
                                        sel_i);
      end
    end
  end

  // Foreground colour
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      foreground_color <= RST_FOREGROUND;
    end else if (ce_i) begin
      if (is_wr(bus_wr, adr_i, OFS_FOREGROUND)) begin
        foreground_color <= merge_bytes(foreground_color, dat_i, sel_i);
      end
    end
  end

  // Plane mask: left out of reset, its content is unknown until written
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (is_wr(bus_wr, adr_i, OFS_PLANE_MASK)) begin
        plane_write_mask <= merge_bytes(plane_write_mask, dat_i,
                                        sel_i);
      end
    end
  end

  // Drawing data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drawing_data_reg <= RST_DRAW_DATA;
    end else if (ce_i) begin
      if (is_wr(bus_wr, adr_i, OFS_DRAW_DATA)) begin
        drawing_data_reg <= merge_bytes(drawing_data_reg, dat_i, sel_i);
      end
    end
  end

  // Mode and depth selection from the mode register's low byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_sel  <= PWMC_SIMPLE;
      depth_sel <= PWMC_BPP8;
    end else if (ce_i) begin
      if (is_wr(bus_wr, adr_i, OFS_MODE) && sel_i[0]) begin
        mode_sel  <= pwmc_mode_t'(dat_i[MODE_SEL_LSB +: 3]);
        depth_sel <= pwmc_depth_t'(dat_i[MODE_DEPTH_LSB +: 2]);
      end
    end
  end

  // Pixel mask with persistent and one-shot aliases
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pixel_write_mask <= RST_PIXEL_MASK;
      pix_oneshot      <= 1'b0;
    end else if (ce_i) begin
      // A write in the same cycle as the consuming operation wins,
      // so a freshly armed mask is never lost
      if (is_wr(bus_wr, adr_i, OFS_PIXEL_PERSIST)) begin
        pixel_write_mask <= merge_bytes(pixel_write_mask, dat_i,
                                        sel_i);
        pix_oneshot      <= 1'b0;
      end else if (is_wr(bus_wr, adr_i, OFS_PIXEL_ONESHOT)) begin
        pixel_write_mask <= merge_bytes(pixel_write_mask, dat_i,
                                        sel_i);
        pix_oneshot      <= 1'b1;
      end else if (op_valid_i && pix_oneshot) begin
        pixel_write_mask <= RST_PIXEL_MASK;
        pix_oneshot      <= 1'b0;
      end
    end
  end

  // Resolve the operation against the state held before this edge
  pwmc_mask_calc u_calc (
    .mode_i      (mode_sel),
    .depth_i     (depth_sel),
    .kind_i      (op_kind_i),
    .wr_data_i   (op_data_i),
    .draw_data_i (drawing_data_reg),
    .pix_mask_i  (pixel_write_mask),
    .bus_be_i    (op_be_i),
    .fg_sel_o    (calc_fg_sel),
    .pix_en_o    (calc_pix_en),
    .byte_en_o   (calc_byte_en)
  );

  // Registered result; later register writes cannot reach back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_valid_o      <= 1'b0;
      res_fg_sel_o     <= RST_ZERO;
      res_pix_en_o     <= RST_ZERO;
      res_byte_en_o    <= 4'h0;
      res_plane_mask_o <= RST_ZERO;
      res_fg_o         <= RST_ZERO;
      res_bg_o         <= RST_ZERO;
    end else if (ce_i) begin
      res_valid_o <= op_valid_i;
      if (op_valid_i) begin
        res_fg_sel_o     <= calc_fg_sel;
        res_pix_en_o     <= calc_pix_en;
        res_byte_en_o    <= calc_byte_en;
        res_plane_mask_o <= plane_write_mask;
        res_fg_o         <= foreground_color;
        res_bg_o         <= background_color;
      end
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    hit     = 1'b1;
    rd_word = RST_ZERO;
    if (adr_i == OFS_BACKGROUND || adr_i == OFS_GREEN_INC ||
        adr_i == OFS_BLUE_INC) begin
      rd_word = background_color;
    end else if (adr_i == OFS_PLANE_MASK) begin
      rd_word = plane_write_mask;
    end else if (adr_i == OFS_PIXEL_PERSIST ||
                 adr_i == OFS_PIXEL_ONESHOT) begin
      rd_word = pixel_write_mask;
    end else if (adr_i == OFS_MODE) begin
      rd_word[MODE_SEL_LSB +: 3]   = mode_sel;
      rd_word[MODE_DEPTH_LSB +: 2] = depth_sel;
      rd_word[MODE_ONESHOT_BIT]    = pix_oneshot;
    end else if (adr_i == OFS_FOREGROUND) begin
      rd_word = foreground_color;
    end else if (adr_i == OFS_DRAW_DATA) begin
      rd_word = drawing_data_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // Read data registered together with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= RST_ZERO;
    end else if (ce_i) begin
      if (bus_req && !ack_o && !we_i && hit) begin
        dat_o <= rd_word;
      end else begin
        dat_o <= RST_ZERO;
      end
    end
  end

endmodule : pwmc_regs

// ---- verification/pwmc_checker.sv ----
`timescale 1ns/1ps
// Port-level checks on the mask and colour bank
module pwmc_checker
  import pwmc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        op_valid_i,
  input wire logic [3:0]  op_be_i,
  input wire logic        res_valid_o,
  input wire logic [31:0] res_fg_sel_o,
  input wire logic [31:0] res_pix_en_o,
  input wire logic [3:0]  res_byte_en_o,
  input wire logic [31:0] res_bg_o
);
  logic        wr;     // Full-word write commits
  logic        bg_hit; // Address lands on background storage
  logic [31:0] bg_sh;  // Expected background
  logic [31:0] pm_sh;  // Expected pixel mask
  logic        arm;    // One-shot armed
  pwmc_mode_t  md;     // Expected drawing mode
  assign wr = ack_o && we_i && cyc_i && stb_i && sel_i == 4'hF;
  assign bg_hit = adr_i == OFS_BACKGROUND || adr_i == OFS_GREEN_INC
               || adr_i == OFS_BLUE_INC;
  // Background and mode shadows; partial-lane writes are not modelled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bg_sh <= 32'h0;
      md    <= PWMC_SIMPLE;
    end else if (wr && bg_hit) begin
      bg_sh <= dat_i;
    end else if (wr && adr_i == OFS_MODE) begin
      md <= pwmc_mode_t'(dat_i[2:0]);
    end
  end
  // Pixel mask shadow, one-shot reverts on any operation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_sh <= 32'hFFFF_FFFF;
      arm   <= 1'b0;
    end else if (wr && adr_i inside {OFS_PIXEL_PERSIST, OFS_PIXEL_ONESHOT}) begin
      pm_sh <= dat_i;
      arm   <= adr_i == OFS_PIXEL_ONESHOT;
    end else if (op_valid_i && ce_i && arm) begin
      pm_sh <= 32'hFFFF_FFFF;
      arm   <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_after_req: assert property (
    cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
    else $error("No ack after a request");
  a_ack_one_cycle: assert property (
    ack_o |=> !ack_o) else $error("Ack longer than one cycle");
  a_res_valid_next: assert property (
    op_valid_i && ce_i |=> res_valid_o)
    else $error("Operation not answered next cycle");
  a_res_only_op: assert property (
    res_valid_o |-> $past(op_valid_i))
    else $error("Result without an operation");
  a_res_hold: assert property (
    !op_valid_i |=> $stable(res_pix_en_o) && $stable(res_fg_sel_o)
    && $stable(res_bg_o)) else $error("Result changed without operation");
  a_bg_snap: assert property (
    op_valid_i && ce_i |=> res_bg_o == $past(bg_sh))
    else $error("Background snapshot wrong");
  a_byte_sub: assert property (
    res_valid_o |-> (res_byte_en_o & ~$past(op_be_i)) == 4'h0)
    else $error("Byte enable beyond bus mask");
  a_stip_mask: assert property (
    op_valid_i && ce_i && md == PWMC_OPQ_STIPPLE
    |=> res_pix_en_o == $past(pm_sh)) else $error("Stipple mask wrong");
  // Main scenarios reached
  c_write: cover property (wr);
  c_oneshot: cover property (op_valid_i && arm);
  c_lanes: cover property (res_valid_o && res_byte_en_o != 4'hF);
endmodule : pwmc_checker

// ---- verification/pwmc_host.sv ----
`timescale 1ns/1ps
// Host master issuing classic single Wishbone cycles
module pwmc_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      wdat_o
);
  // Bus idle at time zero
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} = '0;
  end
  // Whole-word access, all lanes: colours are full 32-bit words
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, wdat_o} <= {2'b11, w, a, 4'hF, d};
    // Wait as long as it takes; only the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    q = rdat_i;
    // Released data shows a changed pattern, not the old word
    {cyc_o, stb_o, wdat_o} <= {2'b00, ~d};
  endtask : acc
endmodule : pwmc_host

// ---- verification/pixel_write_mask_and_color_tb_top.sv ----
`timescale 1ns/1ps
// Self-checking bench for the mask and colour bank
module pixel_write_mask_and_color_tb_top;
  import pwmc_pkg::*;
  logic        clk_i, rst_i, ce_i, ack_o, res_valid_o;
  logic        cyc_i, stb_i, we_i, op_valid_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, op_be_i, res_byte_en_o;
  logic [31:0] dat_i, dat_o, op_data_i, res_fg_sel_o, res_pix_en_o;
  logic [31:0] res_plane_mask_o, res_fg_o, res_bg_o;
  logic [31:0] q;          // Last word read
  pwmc_op_t    op_kind_i;
  int          errors = 0;
  int          n_tests = 0;
  always #50 clk_i = ~clk_i;
  pwmc_regs u_dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .op_valid_i, .op_kind_i, .op_data_i,
    .op_be_i, .res_valid_o, .res_fg_sel_o, .res_pix_en_o, .res_byte_en_o,
    .res_plane_mask_o, .res_fg_o, .res_bg_o);
  pwmc_host u_host (.clk_i, .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .wdat_o(dat_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_host.acc(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic mode(input pwmc_mode_t m, input pwmc_depth_t d);
    wr(OFS_MODE, {26'h0, d, 1'b0, m});
  endtask : mode
  // One operation strobe, result looked at once it has landed
  task automatic op(input pwmc_op_t k, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge clk_i);
    {op_valid_i, op_data_i, op_be_i} <= {1'b1, d, be};
    op_kind_i <= k;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    chk({31'h0, res_valid_o}, 32'h1);
  endtask : op
  task automatic t_reset;
    rd(OFS_BACKGROUND);
    chk(q, 32'h0);
    rd(OFS_PIXEL_PERSIST);
    chk(q, 32'hFFFF_FFFF);
    rd(OFS_MODE);
    chk({31'h0, q[MODE_ONESHOT_BIT]}, 32'h0);
    rd(8'h40);
    chk(q, 32'h0);
  endtask : t_reset
  // Both increment aliases land on background storage
  task automatic t_alias;
    wr(OFS_GREEN_INC, 32'h1122_3344);
    rd(OFS_BACKGROUND);
    chk(q, 32'h1122_3344);
    wr(OFS_BLUE_INC, 32'h5566_7788);
    rd(OFS_BACKGROUND);
    chk(q, 32'h5566_7788);
  endtask : t_alias
  task automatic t_stipple;
    mode(PWMC_OPQ_STIPPLE, PWMC_BPP32);
    wr(OFS_BACKGROUND, 32'h00AB_CDEF);
    wr(OFS_FOREGROUND, 32'h0012_3456);
    // Plane mask aimed at the front buffer only
    wr(OFS_PLANE_MASK, 32'h3C3C_3C3C);
    wr(OFS_PIXEL_PERSIST, 32'h0F0F_00FF);
    op(PWMC_OP_FB_WRITE, 32'hA5A5_0F0F, 4'hF);
    chk(res_fg_sel_o, 32'hA5A5_0F0F);
    chk(res_pix_en_o, 32'h0F0F_00FF);
    chk(res_bg_o, 32'h00AB_CDEF);
    chk(res_fg_o, 32'h0012_3456);
    chk(res_plane_mask_o, 32'h3C3C_3C3C);
    wr(OFS_BACKGROUND, 32'h0000_0077);
    chk(res_bg_o, 32'h00AB_CDEF);
    op(PWMC_OP_COPY_TARGET, 32'h0000_FFFF, 4'hF);
    chk(res_fg_sel_o, 32'h0000_FFFF);
    chk(res_pix_en_o, 32'h0F0F_00FF);
    chk(res_bg_o, 32'h0000_0077);
  endtask : t_stipple
  task automatic t_oneshot;
    wr(OFS_PIXEL_ONESHOT, 32'h0000_F00F);
    rd(OFS_MODE);
    chk({31'h0, q[MODE_ONESHOT_BIT]}, 32'h1);
    op(PWMC_OP_FB_WRITE, 32'h1, 4'hF);
    chk(res_pix_en_o, 32'h0000_F00F);
    rd(OFS_PIXEL_PERSIST);
    chk(q, 32'hFFFF_FFFF);
    rd(OFS_MODE);
    chk({31'h0, q[MODE_ONESHOT_BIT]}, 32'h0);
    op(PWMC_OP_FB_WRITE, 32'h1, 4'hF);
    chk(res_pix_en_o, 32'hFFFF_FFFF);
  endtask : t_oneshot
  // Fill and line take the mask from drawing data
  task automatic t_fill;
    wr(OFS_DRAW_DATA, 32'hC3C3_0001);
    mode(PWMC_OPQ_FILL, PWMC_BPP32);
    wr(OFS_PIXEL_PERSIST, 32'h0000_00FF);
    op(PWMC_OP_FB_WRITE, 32'h1234_0000, 4'hF);
    chk(res_fg_sel_o, 32'hC3C3_0001);
    chk(res_pix_en_o, 32'hFFFF_FFFF);
    mode(PWMC_OPQ_LINE, PWMC_BPP32);
    op(PWMC_OP_SLOPE, 32'h0000_5555, 4'hF);
    chk(res_fg_sel_o, 32'hC3C3_0001);
  endtask : t_fill
  task automatic t_simple;
    mode(PWMC_SIMPLE, PWMC_BPP8);
    wr(OFS_PIXEL_PERSIST, 32'hFFFF_FFF5);
    op(PWMC_OP_FB_WRITE, 32'h0, 4'hF);
    chk({28'h0, res_byte_en_o}, 32'h5);
    mode(PWMC_SIMPLE_Z, PWMC_BPP8);
    op(PWMC_OP_FB_WRITE, 32'h0, 4'hC);
    chk({28'h0, res_byte_en_o}, 32'h4);
    mode(PWMC_SIMPLE, PWMC_BPP24);
    op(PWMC_OP_FB_WRITE, 32'h0, 4'h6);
    chk({28'h0, res_byte_en_o}, 32'h6);
    wr(OFS_PIXEL_PERSIST, 32'hFFFF_FFFE);
    mode(PWMC_SIMPLE_Z, PWMC_BPP12);
    op(PWMC_OP_FB_WRITE, 32'h0, 4'hF);
    chk({28'h0, res_byte_en_o}, 32'h0);
  endtask : t_simple
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // Main sequence after a 12-cycle reset
  initial begin
    {clk_i, rst_i, ce_i} = 3'b011;
    {op_valid_i, op_data_i, op_be_i} = '0;
    op_kind_i = PWMC_OP_FB_WRITE;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_alias;
    t_stipple;
    t_oneshot;
    t_fill;
    t_simple;
    stop_test;
  end
  // Watchdog, roughly 85 times the expected run
  initial begin
    #1000000;
    errors++;
    stop_test;
  end
endmodule : pixel_write_mask_and_color_tb_top
bind pwmc_regs pwmc_checker u_chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .op_valid_i, .op_be_i, .res_valid_o,
  .res_fg_sel_o, .res_pix_en_o, .res_byte_en_o, .res_bg_o);
